// ### src/rail_fault_protection.sv
// Purpose: Fault qualification, latching and gate-drive override for one rail
// Assumes: sys_rst is the power-on reset; comparator pins are asynchronous
// Notes:   PWM requests come from logic on clk and need no synchroniser
`timescale 1ns/10ps
`default_nettype none

module rail_fault_protection #(
  parameter int PHASES = 2
) (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire rail_fault_pkg::cmp_s                  cmp_pins,
  input  wire logic                                  por_done,
  input  wire logic [rail_fault_pkg::CODE_W-1:0]     target_voltage_code,
  input  wire logic [PHASES-1:0]                     phase_active,
  input  wire logic [PHASES-1:0]                     pwm_hs_req,
  input  wire logic [PHASES-1:0]                     pwm_ls_req,
  output logic      [PHASES-1:0]                     hs_drive,
  output logic      [PHASES-1:0]                     ls_drive,
  output logic                                       peer_shutdown_req,
  output rail_fault_pkg::fault_s                     fault_status
);

  localparam logic [7:0] OV_N   = 8'(rail_fault_pkg::OV_DELAY_CYC);
  localparam logic [7:0] UV_N   = 8'(rail_fault_pkg::UV_DELAY_CYC);
  localparam logic [7:0] UVLO_N = 8'(rail_fault_pkg::UVLO_DELAY_CYC);

  // ==========================================================
  // Input synchronisers
  rail_fault_pkg::cmp_s cmp_meta_r;
  rail_fault_pkg::cmp_s cmp_r;
  logic                 por_meta_r;
  logic                 por_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmp_meta_r <= '0;
      cmp_r      <= '0;
      por_meta_r <= 1'b0;
      por_r      <= 1'b0;
    end
    else
    begin
      cmp_meta_r <= cmp_pins;
      cmp_r      <= cmp_meta_r;
      por_meta_r <= por_done;
      por_r      <= por_meta_r;
    end
  end

  // ==========================================================
  // Deglitch counters
  // Saturating count of consecutive cycles the condition has held
  function automatic logic [7:0] dg_next(input logic cond, input logic [7:0] cnt,
                                         input logic [7:0] lim);
    if (!cond)
      dg_next = 8'h00;
    else if (cnt < lim)
      dg_next = cnt + 8'h01;
    else
      dg_next = cnt;
  endfunction

  logic       ov_cond;
  logic [7:0] ov_cnt_r;
  logic [7:0] uv_cnt_r;
  logic [7:0] uvlo_cnt_r;

  // Below the fixed point the threshold is fixed point plus margin
  assign ov_cond = por_r && ((target_voltage_code < rail_fault_pkg::FIXED_POINT_CODE) ?
                   cmp_r.above_fixed_ov : cmp_r.above_ref_ov);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ov_cnt_r   <= 8'h00;
      uv_cnt_r   <= 8'h00;
      uvlo_cnt_r <= 8'h00;
    end
    else
    begin
      ov_cnt_r   <= dg_next(ov_cond, ov_cnt_r, OV_N);
      uv_cnt_r   <= dg_next(cmp_r.below_ref_uv, uv_cnt_r, UV_N);
      uvlo_cnt_r <= dg_next(cmp_r.supply_low, uvlo_cnt_r, UVLO_N);
    end
  end

  // ==========================================================
  // Fault flags; OV and UV latch, lockout and NV follow their conditions
  logic ov_r;
  logic uv_r;
  logic uvlo_r;
  logic nv_r;

  // Only the power-on reset clears OV and UV
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ov_r <= 1'b0;
      uv_r <= 1'b0;
    end
    else
    begin
      if (ov_cnt_r == OV_N)
        ov_r <= 1'b1;
      if (uv_cnt_r == UV_N)
        uv_r <= 1'b1;
    end
  end

  // Lockout follows the supply; it drops as soon as the supply recovers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      uvlo_r <= 1'b0;
    else
      uvlo_r <= (uvlo_cnt_r == UVLO_N);
  end

  // Negative protection only exists inside the OV latch state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      nv_r <= 1'b0;
    else
      nv_r <= ov_r && cmp_r.below_zero;
  end

  // ==========================================================
  // Gate-drive override
  logic [PHASES-1:0] hs_nxt;
  logic [PHASES-1:0] ls_nxt;

  always_comb
  begin
    hs_nxt = pwm_hs_req & phase_active;
    ls_nxt = pwm_ls_req & phase_active;
    if (uvlo_r || uv_r)
    begin
      hs_nxt = '0;
      ls_nxt = '0;
    end
    else if (ov_r)
    begin
      hs_nxt = '0;
      ls_nxt = nv_r ? '0 : phase_active;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hs_drive          <= '0;
      ls_drive          <= '0;
      peer_shutdown_req <= 1'b0;
      fault_status      <= '0;
    end
    else
    begin
      hs_drive          <= hs_nxt;
      ls_drive          <= ls_nxt;
      peer_shutdown_req <= ov_r || uv_r;
      fault_status      <= {ov_r, uv_r, uvlo_r, nv_r};
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ov_set;
    ov_cond [*8] ##1 ov_cond [*8] ##1 ov_cond [*8] ##1 ov_cond |-> ##3 ov_r;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("OV latch not set");

  property p_ov_drive;
    ov_r && !uv_r && !uvlo_r && !nv_r |=> hs_drive == '0 && ls_drive == $past(phase_active);
  endproperty
  a_ov_drive: assert property (p_ov_drive) else $error("OV drive wrong");

  property p_peer;
    $rose(ov_r) || $rose(uv_r) |=> peer_shutdown_req;
  endproperty
  a_peer: assert property (p_peer) else $error("Peer shutdown missing");

  property p_ov_glitch;
    !ov_r && ov_cnt_r < 8'h02 && !ov_cond ##1 ov_cond [*8] ##1 !ov_cond |=> !ov_r;
  endproperty
  a_ov_glitch: assert property (p_ov_glitch) else $error("OV glitch latched");

  property p_nv_off;
    nv_r |=> ls_drive == '0 && hs_drive == '0;
  endproperty
  a_nv_off: assert property (p_nv_off) else $error("NV left switches on");

  property p_nv_ignored;
    !ov_r |=> !nv_r;
  endproperty
  a_nv_ignored: assert property (p_nv_ignored) else $error("NV without OV");

  property p_uv_off;
    uv_r |=> hs_drive == '0 && ls_drive == '0;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("UV left switches on");

  property p_uvlo;
    uvlo_cnt_r == UVLO_N |=> uvlo_r ##1 (hs_drive == '0 && ls_drive == '0);
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("Lockout not enforced");

  property p_ov_por;
    !por_r |-> !ov_cond;
  endproperty
  a_ov_por: assert property (p_ov_por) else $error("OV watched before POR");

  property p_sticky;
    ov_r || uv_r |=> $past(ov_r) <= ov_r && $past(uv_r) <= uv_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Fault latch cleared");

endmodule

`default_nettype wire

// ### src/rail_fault_pkg.sv
// Purpose: Shared constants and carriers for the rail fault protection block
// Assumes: 25 MHz system clock
// Notes:   Comparator levels arrive as one packed bundle
package rail_fault_pkg;

  localparam int CLK_HZ          = 25_000_000;
  localparam int OV_DELAY_NS     = 1000;
  localparam int UV_DELAY_NS     = 3000;
  localparam int UVLO_DELAY_NS   = 3000;
  // Least times, rounded up to whole cycles
  localparam int OV_DELAY_CYC    = (OV_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int UV_DELAY_CYC    = (UV_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int UVLO_DELAY_CYC  = (UVLO_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CNT_W           = 8;
  localparam int CODE_W          = 8;
  // Code standing for the fixed 0.9 V point; plain default
  localparam logic [7:0] FIXED_POINT_CODE = 8'h5A;

  // Analog comparator results, high when the condition holds
  typedef struct packed {
    logic above_ref_ov;   // Sense above reference plus OV margin
    logic above_fixed_ov; // Sense above fixed point plus OV margin
    logic below_zero;     // Sense below 0 V
    logic below_ref_uv;   // Sense below reference minus UV margin
    logic supply_low;     // Supply below power-on threshold
  } cmp_s;

  typedef struct packed {
    logic ov;
    logic uv;
    logic uvlo;
    logic nv;
  } fault_s;

endpackage

// ### sim/gate_model.sv
// Purpose: Gate drivers and companion rail seen from the rail logic
// Assumes: Commands are registered on clk
// Notes:   Flags shoot-through, latches peer requests
`timescale 1ns/10ps
`default_nettype none
module gate_model #(
  parameter int PHASES = 2
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [PHASES-1:0] hs,
  input  wire logic [PHASES-1:0] ls,
  input  wire logic              peer,
  output logic                   seen,
  output logic                   clash
);
  // ====
  // Companion rail latches the request until model reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      seen  <= 1'b0;
      clash <= 1'b0;
    end
    else
    begin
      seen  <= seen | peer;
      clash <= clash | (|(hs & ls));
    end
  end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for rail fault protection
// Assumes: 25 MHz clock, inputs move at the falling edge
// Notes:   One task per scenario
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                 clk, sys_rst, por_done, seen, clash, peer, model_rst;
  rail_fault_pkg::cmp_s cmp;
  rail_fault_pkg::fault_s fs;
  logic [7:0]           code;
  logic [1:0]           act, hreq, lreq, hs, ls;
  int                   miscompares, num_checks, n;
  rail_fault_protection #(.PHASES(2)) uut (.clk(clk), .sys_rst(sys_rst),
    .cmp_pins(cmp), .por_done(por_done), .target_voltage_code(code),
    .phase_active(act), .pwm_hs_req(hreq), .pwm_ls_req(lreq), .hs_drive(hs),
    .ls_drive(ls), .peer_shutdown_req(peer), .fault_status(fs));
  // Model keeps its history across the block's own resets
  gate_model #(.PHASES(2)) drv (.clk(clk), .sys_rst(model_rst), .hs(hs),
    .ls(ls), .peer(peer), .seen(seen), .clash(clash));
  // ====
  // Helpers
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait for fault bits, n counts cycles from the pin change
  task automatic wt(input logic [3:0] m);
    n = 0;
    while ((fs & m) !== m)
    begin
      @(negedge clk);
      n++;
      if (n > 120)
      begin
        miscompares++;
        close_out();
      end
    end
  endtask
  task automatic rst(input logic done);
    sys_rst = 1'b1;
    cmp = '0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    por_done = done;
    repeat (4) @(negedge clk);
  endtask
  task automatic hold(input int c);
    repeat (c) @(negedge clk);
  endtask
  // ====
  // Scenarios
  task automatic t_pre;
    rst(1'b0);
    model_rst = 1'b0;
    cmp.above_ref_ov = 1'b1;
    cmp.below_zero = 1'b1;
    hold(40);
    chk(fs, 4'h0);
    cmp.above_ref_ov = 1'b0;
    por_done = 1'b1;
    hold(40);
    chk(fs, 4'h0);
    chk(4'(hs), 4'(hreq & act));
    chk(4'(ls), 4'(lreq & act));
    cmp.below_zero = 1'b0;
    cmp.above_ref_ov = 1'b1;
    hold(20);
    cmp.above_ref_ov = 1'b0;
    hold(15);
    chk(fs, 4'h0);
    cmp.above_ref_ov = 1'b1;
    hold(8);
    cmp.above_ref_ov = 1'b0;
    hold(15);
    chk(fs, 4'h0);
    $display("t_pre done");
  endtask
  task automatic t_ov;
    act = 2'h1;
    cmp.above_ref_ov = 1'b1;
    wt(4'h8);
    chk({3'h0, n >= 25 && n <= 35}, 4'h1);
    hold(2);
    chk(4'(hs), 4'h0);
    chk(4'(ls), 4'(act));
    chk({3'h0, peer}, 4'h1);
    cmp.above_ref_ov = 1'b0;
    cmp.below_zero = 1'b1;
    hold(6);
    chk({hs, ls}, 4'h0);
    chk(fs, 4'h9);
    cmp.below_zero = 1'b0;
    hold(6);
    chk(4'(ls), 4'(act));
    chk(fs, 4'h8);
    act = 2'h3;
    $display("t_ov done");
  endtask
  task automatic t_fix;
    rst(1'b1);
    code = 8'h59;
    cmp.above_ref_ov = 1'b1;
    hold(40);
    chk(fs, 4'h0);
    cmp.above_fixed_ov = 1'b1;
    wt(4'h8);
    chk({3'h0, n <= 35}, 4'h1);
    code = 8'h5A;
    $display("t_fix done");
  endtask
  task automatic t_uv;
    rst(1'b1);
    cmp.below_ref_uv = 1'b1;
    hold(70);
    cmp.below_ref_uv = 1'b0;
    hold(10);
    chk(fs, 4'h0);
    cmp.below_ref_uv = 1'b1;
    wt(4'h4);
    chk({3'h0, n >= 75 && n <= 85}, 4'h1);
    hold(2);
    chk({hs, ls}, 4'h0);
    chk({3'h0, peer}, 4'h1);
    cmp.below_ref_uv = 1'b0;
    hold(8);
    chk(fs, 4'h4);
    $display("t_uv done");
  endtask
  task automatic t_uvlo;
    rst(1'b1);
    cmp.supply_low = 1'b1;
    wt(4'h2);
    chk({3'h0, n >= 75 && n <= 85}, 4'h1);
    hold(2);
    chk({hs, ls}, 4'h0);
    cmp.supply_low = 1'b0;
    hold(8);
    chk(fs, 4'h0);
    chk({hs, ls}, {hreq & act, lreq & act});
    $display("t_uvlo done");
  endtask
  initial
  begin
    {sys_rst, por_done, miscompares, num_checks} = '0;
    model_rst = 1'b1;
    cmp = '0;
    code = 8'h5A;
    act = 2'h3;
    hreq = 2'h1;
    lreq = 2'h2;
    t_pre();
    t_ov();
    t_fix();
    t_uv();
    t_uvlo();
    chk({seen, clash, 2'h0}, 4'h8);
    close_out();
  end
endmodule
`default_nettype wire
